//--- pkg/isacd_pkg.sv
// Package of opcodes, field positions, reset values and timing counts for the subset decoder.
package isacd_pkg;

  // ==========================================================================
  // Major opcodes
  localparam logic [5:0] OP_SPECIAL  = 6'h00;
  localparam logic [5:0] OP_REGIMM   = 6'h01;
  localparam logic [5:0] OP_SYSCOP   = 6'h10;
  localparam logic [5:0] OP_FPCOP    = 6'h11;
  localparam logic [5:0] OP_SECOND_COPROCESSOR_OPCODE     = 6'h12;
  localparam logic [5:0] OP_FPCOP_X  = 6'h13;
  localparam logic [5:0] OP_SECOND_SPECIAL_MAJOR_OPCODE = 6'h1c;
  localparam logic [5:0] OP_LOAD_WORD_COPROC_TWO     = 6'h32;
  localparam logic [5:0] OP_LOAD_DWORD_COPROC_TWO     = 6'h36;
  localparam logic [5:0] OP_STORE_WORD_COPROC_TWO     = 6'h3a;
  localparam logic [5:0] OP_STORE_DWORD_COPROC_TWO     = 6'h3e;
  localparam logic [5:0] OP_ADDIU    = 6'h09;
  localparam logic [5:0] OP_UNUSED   = 6'h3b;

  // ==========================================================================
  // Function codes of the first special opcode
  localparam logic [5:0] FN_MOVCI = 6'h01;
  localparam logic [5:0] FN_MFHI  = 6'h10;
  localparam logic [5:0] FN_MTHI  = 6'h11;
  localparam logic [5:0] FN_MFLO  = 6'h12;
  localparam logic [5:0] FN_MTLO  = 6'h13;

  // ==========================================================================
  // Format field values of the floating point coprocessor
  localparam logic [4:0] FMT_S  = 5'h10;
  localparam logic [4:0] FMT_D  = 5'h11;
  localparam logic [4:0] FMT_W  = 5'h14;
  localparam logic [4:0] FMT_L  = 5'h15;
  localparam logic [4:0] FMT_PS = 5'h16;
  localparam logic [2:0] FMT3_PS = 3'h6;

  // ==========================================================================
  // System coprocessor operations
  localparam logic [5:0] CO_TLBR  = 6'h01;
  localparam logic [5:0] CO_TLBWI = 6'h02;
  localparam logic [5:0] CO_TLBWR = 6'h06;
  localparam logic [5:0] CO_TLBP  = 6'h08;
  localparam logic [5:0] CO_ERET  = 6'h18;

  // ==========================================================================
  // Processor status register layout and system coprocessor register map
  localparam int          STATUS_SUPV_BIT  = 3;
  localparam logic [31:0] STATUS_RESET     = 32'h0040_0004;
  localparam logic [31:0] STATUS_WR_MASK   = 32'hf7ff_ff1f;
  localparam logic [31:0] SYSCOP_REG_MAP   = 32'hf1ff_ffff;

  // ==========================================================================
  // Multiply and divide unit latencies in clock cycles
  localparam int MUL_CYCLES = 4;
  localparam int DIV_CYCLES = 36;

  // ==========================================================================
  // Alignment masks for the low address bits.
  localparam logic [2:0] ALIGN_BYTE = 3'h0;
  localparam logic [2:0] ALIGN_HALF = 3'h1;
  localparam logic [2:0] ALIGN_WORD = 3'h3;
  localparam logic [2:0] ALIGN_DBL  = 3'h7;

endpackage : isacd_pkg

//--- design/isacd_hilo_lock.sv
// Interlock of the high and low result registers against running multiply and divide work.
`timescale 1ns/1ps
module isacd_hilo_lock
  import isacd_pkg::*;
#(
  parameter int MUL_LAT = MUL_CYCLES,
  parameter int DIV_LAT = DIV_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Issue of a multiply or divide operation
  input  wire logic md_issue,
  input  wire logic md_is_div,
  // Use of the result registers by the next instruction
  input  wire logic hilo_use,
  // Interlock state
  output logic      hilo_busy,
  output logic      hilo_stall
);

  // ==========================================================================
  // Busy counter
  logic [7:0] cnt_q;

  // Loads the unit latency on issue and counts down to idle.
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 8'h00;
    end else if (md_issue) begin
      cnt_q <= md_is_div ? 8'(DIV_LAT) : 8'(MUL_LAT); // RULE12
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  // Any access to the result registers waits while the unit works.
  assign hilo_busy  = (cnt_q != 8'h00);
  assign hilo_stall = hilo_busy & hilo_use; // RULE12

  // A new operation always leaves the unit busy on the next cycle.
  chk_issue_busy: assert property (@(posedge clk) disable iff (srst) // RULE12
    md_issue |=> hilo_busy) else $error("Result unit not busy after issue.");

  // A multiply keeps the unit busy for exactly its latency.
  chk_mul_length: assert property (@(posedge clk) disable iff (srst) // RULE12
    md_issue && !md_is_div |=> hilo_busy [*4] ##1 (!hilo_busy || $past(md_issue)))
    else $error("Multiply busy window has the wrong length.");

endmodule // isacd_hilo_lock

//--- design/isacd_decode.sv
// Compliance and subset decoder: legality, exceptions, alignment, status masking and interlock.
// ============================================================================
// Summary of operation
// RULE1 - Every integer instruction decodes as legal.
// RULE2 - Floating point unit optional, with its conditional moves.
// RULE3 - Without wide addressing, addresses stay 32-bit.
// RULE4 - No supervisor mode: status bit three zero.
// RULE5 - Simple mapping unit keeps privileged interface unchanged.
// RULE6 - Translation buffer operations use standard encodings only.
// RULE7 - Reserved register fields carry no function.
// RULE8 - Unused system register encodings stay unassigned.
// RULE9 - Extensions only in sanctioned opcode spaces.
// RULE10 - Omitted instructions raise reserved or unusable exception.
// RULE11 - Alignment checked on effective address only.
// RULE12 - Result registers fully interlocked in hardware.
// RULE13 - Paired single needs a floating point unit.
`timescale 1ns/1ps
module isacd_decode
  import isacd_pkg::*;
#(
  parameter int MUL_LAT = MUL_CYCLES,
  parameter int DIV_LAT = DIV_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Implementation options
  input  wire logic        fpu_present,
  input  wire logic        ps_present,
  input  wire logic        addr64_impl,
  input  wire logic        supervisor_impl,
  input  wire logic        mmu_is_tlb,
  input  wire logic        second_coprocessor_opcode_present,
  input  wire logic        partner_ext_en,
  // Current mode
  input  wire logic        cu0_usable,
  input  wire logic        cu1_usable,
  input  wire logic        cu2_usable,
  input  wire logic        addr64_enable,
  // Instruction stream
  input  wire logic        instr_valid,
  output logic             instr_ready,
  input  wire logic [31:0] instr,
  input  wire logic [63:0] instr_ea,
  // Decode results
  output logic             dec_valid_q,
  output logic             exc_ri_q,
  output logic             exc_cpu_q,
  output logic [1:0]       exc_cpu_num_q,
  output logic             exc_addr_load_q,
  output logic             exc_addr_store_q,
  output logic             md_op_q,
  output logic             tlb_op_q,
  output logic             second_coprocessor_opcode_op_q,
  output logic             partner_op_q,
  output logic             ps_op_q,
  output logic             syscop_reg_ok_q,
  output logic             mmu_addr64_q,
  // Processor status register
  input  wire logic        status_wr,
  input  wire logic [31:0] status_wdata,
  output logic [31:0]      status_rdata,
  // Result register interlock
  output logic             hilo_busy
);

  // ==========================================================================
  // Instruction fields
  logic [5:0] op;
  logic [4:0] rs;
  logic [4:0] rt;
  logic [4:0] rd;
  logic [5:0] fn;
  logic       accept;
  logic       hilo_stall;
  logic       ps_ok;
  logic       addr64_eff;

  assign op = instr[31:26];
  assign rs = instr[25:21];
  assign rt = instr[20:16];
  assign rd = instr[15:11];
  assign fn = instr[5:0];

  // Paired single exists only on top of a present floating point unit.
  assign ps_ok      = fpu_present & ps_present; // RULE13
  // Wide addressing is off for good when the option is absent.
  assign addr64_eff = addr64_impl & addr64_enable; // RULE3

  // ==========================================================================
  // Combinational decode
  logic       ri;
  logic       cpu;
  logic [1:0] cpu_num;
  logic       is_ld;
  logic       is_st;
  logic [2:0] align;
  logic       md_issue;
  logic       md_div;
  logic       hilo_use;
  logic       tlb;
  logic       c2;
  logic       partner;
  logic       ps;
  logic       cp0_reg;

  // Classifies the instruction and chooses the exception for omitted parts.
  always_comb begin
    ri       = 1'b0;
    cpu      = 1'b0;
    cpu_num  = 2'h0;
    is_ld    = 1'b0;
    is_st    = 1'b0;
    align    = ALIGN_BYTE;
    md_issue = 1'b0;
    md_div   = 1'b0;
    hilo_use = 1'b0;
    tlb      = 1'b0;
    c2       = 1'b0;
    partner  = 1'b0;
    ps       = 1'b0;
    cp0_reg  = 1'b0;
    unique case (op)
      OP_SPECIAL: begin
        unique case (fn)
          6'h05, 6'h0e, 6'h15, 6'h28, 6'h29, 6'h35, 6'h37, 6'h39, 6'h3d: ri = 1'b1; // RULE10
          FN_MOVCI: begin
            if (!cu1_usable) begin
              cpu     = 1'b1; // RULE2
              cpu_num = 2'h1;
            end else if (!fpu_present) begin
              ri = 1'b1; // RULE2
            end
          end
          FN_MFHI, FN_MTHI, FN_MFLO, FN_MTLO: hilo_use = 1'b1; // RULE12
          6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f: begin
            hilo_use = 1'b1; // RULE12
            md_issue = 1'b1;
            md_div   = fn[1];
          end
          default: ri = 1'b0; // RULE1
        endcase
      end
      OP_REGIMM: begin
        unique case (rt)
          5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e,
          5'h10, 5'h11, 5'h12, 5'h13: ri = 1'b0; // RULE1
          default: ri = 1'b1; // RULE10
        endcase
      end
      OP_SYSCOP: begin
        if (!cu0_usable) begin
          cpu = 1'b1; // RULE10
        end else if (rs == 5'h00 || rs == 5'h01 || rs == 5'h04 || rs == 5'h05) begin
          cp0_reg = SYSCOP_REG_MAP[rd]; // RULE8
        end else if (rs[4]) begin
          unique case (fn)
            CO_TLBR, CO_TLBWI, CO_TLBWR, CO_TLBP: tlb = 1'b1; // RULE5
            CO_ERET: ri = 1'b0;
            default: ri = 1'b1; // RULE8
          endcase
        end else begin
          ri = 1'b1; // RULE10
        end
      end
      OP_FPCOP, OP_FPCOP_X, 6'h31, 6'h35, 6'h39, 6'h3d: begin
        if (!cu1_usable) begin
          cpu     = 1'b1; // RULE10
          cpu_num = 2'h1;
        end else if (!fpu_present) begin
          ri = 1'b1; // RULE2
        end else if (op == OP_FPCOP) begin
          unique case (rs)
            5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h06, 5'h08,
            FMT_S, FMT_D, FMT_W, FMT_L: ri = 1'b0; // RULE2
            FMT_PS: begin
              ps = 1'b1;
              ri = !ps_ok; // RULE13
            end
            default: ri = 1'b1; // RULE10
          endcase
        end else if (op == OP_FPCOP_X) begin
          is_ld = (fn == 6'h00) || (fn == 6'h01);
          is_st = (fn == 6'h08) || (fn == 6'h09);
          align = fn[0] ? ALIGN_DBL : ALIGN_WORD; // RULE11
          if (fn[5] && fn[2:0] == FMT3_PS) begin
            ps = 1'b1;
            ri = !ps_ok; // RULE13
          end
        end else begin
          is_ld = !op[3];
          is_st = op[3];
          align = op[2] ? ALIGN_DBL : ALIGN_WORD; // RULE11
        end
      end
      OP_SECOND_COPROCESSOR_OPCODE, OP_LOAD_WORD_COPROC_TWO, OP_LOAD_DWORD_COPROC_TWO, OP_STORE_WORD_COPROC_TWO, OP_STORE_DWORD_COPROC_TWO: begin
        if (!cu2_usable) begin
          cpu     = 1'b1; // RULE10
          cpu_num = 2'h2;
        end else if (!second_coprocessor_opcode_present) begin
          ri = 1'b1; // RULE10
        end else begin
          c2    = 1'b1; // RULE9
          is_ld = (op != OP_SECOND_COPROCESSOR_OPCODE) && !op[3];
          is_st = (op != OP_SECOND_COPROCESSOR_OPCODE) && op[3];
          align = op[2] ? ALIGN_DBL : ALIGN_WORD;
        end
      end
      OP_SECOND_SPECIAL_MAJOR_OPCODE: begin
        unique case (fn)
          6'h00, 6'h01, 6'h04, 6'h05, 6'h02: begin
            hilo_use = 1'b1; // RULE12
            md_issue = 1'b1;
          end
          6'h20, 6'h21, 6'h24, 6'h25: ri = 1'b0; // RULE1
          default: begin
            partner = partner_ext_en; // RULE9
            ri      = !partner_ext_en;
          end
        endcase
      end
      6'h1d, 6'h1e, 6'h1f, OP_UNUSED: ri = 1'b1; // RULE9
      default: begin
        // Remaining major opcodes are integer instructions, all implemented.
        is_ld = (op[5:3] == 3'h4) || (op == 6'h30) || (op == 6'h34) || (op == 6'h37);
        is_st = (op[5:3] == 3'h5 && op != 6'h2f) || (op == 6'h38) || (op == 6'h3c) ||
                (op == 6'h3f); // RULE1
        unique case (op)
          6'h21, 6'h25, 6'h29:                      align = ALIGN_HALF;
          6'h23, 6'h27, 6'h2b, 6'h30, 6'h38:        align = ALIGN_WORD;
          6'h34, 6'h37, 6'h3c, 6'h3f:               align = ALIGN_DBL;
          default:                                  align = ALIGN_BYTE;
        endcase
      end
    endcase
  end

  // ==========================================================================
  // Address checks
  logic ea_compat;
  logic ea_misalign;
  logic ea_bad;

  // Only the effective address is tested, never the base register.
  assign ea_misalign = |(instr_ea[2:0] & align); // RULE11
  // Without wide addressing the address must be a sign-extended 32-bit one.
  assign ea_compat   = (&instr_ea[63:31]) | ~(|instr_ea[63:31]); // RULE3
  assign ea_bad      = ea_misalign | (!addr64_eff & !ea_compat);

  // ==========================================================================
  // Handshake and interlock
  assign accept      = instr_valid & !hilo_stall;
  assign instr_ready = !hilo_stall; // RULE12

  isacd_hilo_lock #(
    .MUL_LAT (MUL_LAT),
    .DIV_LAT (DIV_LAT)
  ) u_hilo_lock (
    .clk        (clk),
    .srst       (srst),
    .md_issue   (accept & md_issue & !ri & !cpu),
    .md_is_div  (md_div),
    .hilo_use   (instr_valid & hilo_use),
    .hilo_busy  (hilo_busy),
    .hilo_stall (hilo_stall)
  );

  // ==========================================================================
  // Registered decode results
  always_ff @(posedge clk) begin
    if (srst) begin
      dec_valid_q      <= 1'b0;
      exc_ri_q         <= 1'b0;
      exc_cpu_q        <= 1'b0;
      exc_cpu_num_q    <= 2'h0;
      exc_addr_load_q  <= 1'b0;
      exc_addr_store_q <= 1'b0;
    end else begin
      dec_valid_q      <= accept;
      exc_ri_q         <= accept & ri & !cpu; // RULE10
      exc_cpu_q        <= accept & cpu;
      exc_cpu_num_q    <= accept ? cpu_num : 2'h0;
      exc_addr_load_q  <= accept & !ri & !cpu & is_ld & ea_bad; // RULE11
      exc_addr_store_q <= accept & !ri & !cpu & is_st & ea_bad;
    end
  end

  // Dispatch flags for the units that carry out the operation.
  always_ff @(posedge clk) begin
    if (srst) begin
      md_op_q         <= 1'b0;
      tlb_op_q        <= 1'b0;
      second_coprocessor_opcode_op_q       <= 1'b0;
      partner_op_q    <= 1'b0;
      ps_op_q         <= 1'b0;
      syscop_reg_ok_q <= 1'b0;
    end else begin
      md_op_q         <= accept & md_issue;
      tlb_op_q        <= accept & tlb & mmu_is_tlb; // RULE6
      second_coprocessor_opcode_op_q       <= accept & c2;
      partner_op_q    <= accept & partner;
      ps_op_q         <= accept & ps & ps_ok;
      syscop_reg_ok_q <= accept & cp0_reg; // RULE8
    end
  end

  // The translation unit is told whether wide addressing is in force.
  always_ff @(posedge clk) begin
    if (srst) begin
      mmu_addr64_q <= 1'b0;
    end else begin
      mmu_addr64_q <= addr64_eff; // RULE3
    end
  end

  // ==========================================================================
  // Processor status register
  logic [31:0] status_q;
  logic [31:0] status_mask;

  // Reserved bits, and the supervisor bit when absent, never store a value.
  always_comb begin
    status_mask = STATUS_WR_MASK; // RULE7
    status_mask[STATUS_SUPV_BIT] = supervisor_impl; // RULE4
  end

  // Holds the writable status bits.
  always_ff @(posedge clk) begin
    if (srst) begin
      status_q <= STATUS_RESET & STATUS_WR_MASK;
    end else if (status_wr) begin
      status_q <= status_wdata & status_mask; // RULE4
    end
  end

  assign status_rdata = status_q & status_mask; // RULE4

  // ==========================================================================
  // Checks
  chk_supv_bit_zero: assert property (@(posedge clk) disable iff (srst) // RULE4
    !supervisor_impl |-> !status_rdata[STATUS_SUPV_BIT])
    else $error("Status bit three visible without supervisor mode.");

  chk_ps_needs_fpu: assert property (@(posedge clk) disable iff (srst) // RULE13
    accept && op == OP_FPCOP && rs == FMT_PS && !ps_ok |=> exc_ri_q || exc_cpu_q)
    else $error("Paired single accepted without support.");

  chk_fp_move_gone: assert property (@(posedge clk) disable iff (srst) // RULE2
    accept && op == OP_SPECIAL && fn == FN_MOVCI && !cu1_usable
    |=> exc_cpu_q && exc_cpu_num_q == 2'h1)
    else $error("Floating point move did not raise unusable exception.");

  chk_word_align: assert property (@(posedge clk) disable iff (srst) // RULE11
    accept && op == 6'h23 && instr_ea[1:0] != 2'h0 |=> exc_addr_load_q)
    else $error("Misaligned word load not flagged.");

  chk_addr_narrow: assert property (@(posedge clk) disable iff (srst) // RULE3
    accept && op == 6'h20 && !addr64_impl && !ea_compat |=> exc_addr_load_q)
    else $error("Wide address used without wide addressing.");

  chk_unused_op: assert property (@(posedge clk) disable iff (srst) // RULE10
    accept && op == OP_UNUSED |=> exc_ri_q && !exc_cpu_q)
    else $error("Unused opcode not reserved.");

  chk_int_legal: assert property (@(posedge clk) disable iff (srst) // RULE1
    accept && op == OP_ADDIU |=> !exc_ri_q && !exc_cpu_q)
    else $error("Integer instruction refused.");

  chk_partner_gate: assert property (@(posedge clk) disable iff (srst) // RULE9
    accept && op == OP_SECOND_SPECIAL_MAJOR_OPCODE && fn == 6'h3e && !partner_ext_en
    |=> exc_ri_q && !partner_op_q)
    else $error("Partner function accepted while disabled.");

  chk_hilo_wait: assert property (@(posedge clk) disable iff (srst) // RULE12
    hilo_busy && instr_valid && op == OP_SPECIAL && fn == FN_MFLO |-> !instr_ready)
    else $error("Result read not held during multiply.");

  chk_tlb_iface: assert property (@(posedge clk) disable iff (srst) // RULE5
    accept && op == OP_SYSCOP && rs[4] && fn == CO_TLBWI && cu0_usable
    |=> !exc_ri_q && tlb_op_q == $past(mmu_is_tlb))
    else $error("Translation operation decoded differently with simple mapping.");

endmodule // isacd_decode

//--- verif/isacd_tb.sv
// Self-checking testbench for the compliance and subset decoder.
`timescale 1ns/1ps
module tb;
  import isacd_pkg::*;

  // ==========================================================================
  // Constants and signals
  localparam int          MUL_T = 4;
  localparam int          DIV_T = 6;
  localparam logic [12:0] ALL   = 13'h1fff;
  localparam logic [12:0] F_DV  = 13'h1000;
  localparam logic [12:0] F_RI  = 13'h0800;
  localparam logic [12:0] F_CPU = 13'h0400;
  localparam logic [12:0] F_AL  = 13'h0080;
  localparam logic [12:0] F_AS  = 13'h0040;
  localparam logic [12:0] F_MD  = 13'h0020;
  localparam logic [12:0] F_TLB = 13'h0010;
  localparam logic [12:0] F_C2  = 13'h0008;
  localparam logic [12:0] F_PT  = 13'h0004;
  localparam logic [12:0] F_PS  = 13'h0002;
  localparam logic [12:0] F_SR  = 13'h0001;
  localparam logic [5:0]  MOP [8] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h29, 6'h2b, 6'h37, 6'h3f};
  localparam logic [2:0]  MAL [8] = '{3'h0, 3'h1, 3'h0, 3'h3, 3'h1, 3'h3, 3'h7, 3'h7};
  localparam logic [5:0]  TOP [4] = '{CO_TLBR, CO_TLBWI, CO_TLBWR, CO_TLBP};
  localparam logic [5:0]  C2P [4] = '{OP_LOAD_WORD_COPROC_TWO, OP_STORE_WORD_COPROC_TWO, OP_LOAD_DWORD_COPROC_TWO, OP_STORE_DWORD_COPROC_TWO};
  localparam logic [4:0]  FMS [3] = '{FMT_D, FMT_W, FMT_L};
  localparam logic [31:0] PRD [3] = '{32'h0085_0018, 32'h0085_001a, 32'h7085_0000};
  localparam logic [31:0] CNS [3] = '{32'h0000_1012, 32'h0080_0011, 32'h0080_0013};
  localparam int          LAT [3] = '{MUL_T, DIV_T, MUL_T};
  localparam logic [31:0] FP_S    = {OP_FPCOP, FMT_S, 21'h0};
  localparam logic [31:0] FP_PS   = {OP_FPCOP, FMT_PS, 21'h0};
  localparam logic [31:0] MOVCI   = {OP_SPECIAL, 20'h80100, FN_MOVCI};
  localparam logic [31:0] LW_I    = 32'h8c22_0000;

  logic        clk, srst, fpu_present, ps_present, addr64_impl, supervisor_impl;
  logic        mmu_is_tlb, second_coprocessor_opcode_present, partner_ext_en, cu0_usable, cu1_usable;
  logic        cu2_usable, addr64_enable, instr_valid, instr_ready, status_wr;
  logic        dec_valid_q, exc_ri_q, exc_cpu_q, exc_addr_load_q, exc_addr_store_q;
  logic        md_op_q, tlb_op_q, second_coprocessor_opcode_op_q, partner_op_q, ps_op_q, syscop_reg_ok_q;
  logic        mmu_addr64_q, hilo_busy;
  logic [1:0]  exc_cpu_num_q;
  logic [31:0] instr, status_wdata, status_rdata;
  logic [63:0] instr_ea;
  logic [12:0] dec_flags;
  int          failures, total_checks, stalls;

  // Packs all decode pulses into one word for comparison.
  assign dec_flags = {dec_valid_q, exc_ri_q, exc_cpu_q, exc_cpu_num_q, exc_addr_load_q,
                      exc_addr_store_q, md_op_q, tlb_op_q, second_coprocessor_opcode_op_q, partner_op_q,
                      ps_op_q, syscop_reg_ok_q};

  isacd_decode #(.MUL_LAT(MUL_T), .DIV_LAT(DIV_T)) DUT (
    .clk(clk), .srst(srst), .fpu_present(fpu_present), .ps_present(ps_present),
    .addr64_impl(addr64_impl), .supervisor_impl(supervisor_impl), .mmu_is_tlb(mmu_is_tlb),
    .second_coprocessor_opcode_present(second_coprocessor_opcode_present), .partner_ext_en(partner_ext_en), .cu0_usable(cu0_usable),
    .cu1_usable(cu1_usable), .cu2_usable(cu2_usable), .addr64_enable(addr64_enable),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .instr(instr),
    .instr_ea(instr_ea), .dec_valid_q(dec_valid_q), .exc_ri_q(exc_ri_q),
    .exc_cpu_q(exc_cpu_q), .exc_cpu_num_q(exc_cpu_num_q), .exc_addr_load_q(exc_addr_load_q),
    .exc_addr_store_q(exc_addr_store_q), .md_op_q(md_op_q), .tlb_op_q(tlb_op_q),
    .second_coprocessor_opcode_op_q(second_coprocessor_opcode_op_q), .partner_op_q(partner_op_q), .ps_op_q(ps_op_q),
    .syscop_reg_ok_q(syscop_reg_ok_q), .mmu_addr64_q(mmu_addr64_q), .status_wr(status_wr),
    .status_wdata(status_wdata), .status_rdata(status_rdata), .hilo_busy(hilo_busy)
  );

  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cuts a hung run short and counts it as a mismatch.
  initial begin
    #2000000;
    failures++;
    print_verdict();
  end

  // ==========================================================================
  // Tasks
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // Offers one instruction at a falling edge, counts refused cycles, checks the pulses.
  task automatic send(input logic [31:0] w, input logic [63:0] ea, input logic [12:0] m,
                      input logic [12:0] exp);
    int i;
    instr       = w;
    instr_ea    = ea;
    instr_valid = 1'b1;
    for (i = 0; i < 200; i++) begin
      #1;
      if (instr_ready === 1'b1) break;
      @(negedge clk);
    end
    stalls = i;
    if (i == 200) begin
      failures++;
      print_verdict();
    end
    @(negedge clk);
    check(dec_flags & m, exp);
  endtask

  // Writes the status register through its strobe, then lets one idle cycle pass.
  task automatic wr_status(input logic [31:0] d);
    status_wr    = 1'b1;
    status_wdata = d;
    @(negedge clk);
    status_wr    = 1'b0;
    @(negedge clk);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {srst, fpu_present, ps_present, addr64_impl, supervisor_impl, mmu_is_tlb} = 6'h20;
    {second_coprocessor_opcode_present, partner_ext_en, cu1_usable, cu2_usable, addr64_enable} = 5'h00;
    {instr_valid, status_wr, instr, instr_ea, status_wdata} = '0;
    cu0_usable = 1'b1;
    failures = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    check(status_rdata, STATUS_RESET & STATUS_WR_MASK);
    check(dec_flags, 13'h0);
    wr_status(32'hffff_ffff);
    check(status_rdata, STATUS_WR_MASK & 32'hffff_fff7);
    supervisor_impl = 1'b1;
    wr_status(32'h0000_0008);
    check(status_rdata, 32'h0000_0008);
    supervisor_impl = 1'b0;
    #1;
    check(status_rdata, 32'h0000_0000);
    @(negedge clk);
    // Integer work and ignored reserved fields.
    send({OP_ADDIU, 26'h0220010}, 64'h0, ALL, F_DV);
    send(32'h03ff_1010, 64'h0, ~F_MD, F_DV);
    // Floating point subsets.
    ps_present = 1'b1;
    send(FP_S, 64'h0, ALL, F_DV | F_CPU | 13'h0100);
    send(MOVCI, 64'h0, ALL, F_DV | F_CPU | 13'h0100);
    cu1_usable = 1'b1;
    send(FP_PS, 64'h0, ALL, F_DV | F_RI);
    send(MOVCI, 64'h0, ALL, F_DV | F_RI);
    fpu_present = 1'b1;
    send(FP_S, 64'h0, ALL, F_DV);
    send(MOVCI, 64'h0, ALL, F_DV);
    send(FP_PS, 64'h0, ALL, F_DV | F_PS);
    ps_present = 1'b0;
    send(FP_PS, 64'h0, ALL, F_DV | F_RI);
    for (int f = 0; f < 3; f++) send({OP_FPCOP, FMS[f], 21'h0}, 64'h0, ALL, F_DV);
    // Alignment on the effective address, with an odd offset field.
    for (int o = 0; o < 8; o++) begin
      for (int a = 0; a < 8; a++) begin
        send({MOP[o], 10'h062, 16'h0003}, 64'(a), ALL, F_DV | (((3'(a) & MAL[o]) == 3'h0) ?
             13'h0 : (MOP[o][3] ? F_AS : F_AL)));
      end
    end
    // Address space without and with wide addressing.
    addr64_enable = 1'b1;
    send(LW_I, 64'h1_0000_0000, ALL, F_DV | F_AL);
    send({6'h20, 26'h0}, 64'h1_0000_0000, ALL, F_DV | F_AL);
    check(mmu_addr64_q, 1'b0);
    send(LW_I, 64'hffff_ffff_8000_0000, ALL, F_DV);
    addr64_impl = 1'b1;
    send(LW_I, 64'h1_0000_0000, ALL, F_DV);
    check(mmu_addr64_q, 1'b1);
    // System coprocessor registers and translation buffer operations.
    mmu_is_tlb = 1'b1;
    send({OP_SYSCOP, 26'h0026000}, 64'h0, ALL, F_DV | F_SR);
    send({OP_SYSCOP, 26'h002c800}, 64'h0, ALL, F_DV);
    send({OP_SYSCOP, 26'h002b000}, 64'h0, ALL, F_DV | F_SR);
    for (int t = 0; t < 4; t++) send({OP_SYSCOP, 20'h80000, TOP[t]}, 64'h0, ALL, F_DV | F_TLB);
    send({OP_SYSCOP, 20'h80000, 6'h03}, 64'h0, F_TLB, 13'h0);
    mmu_is_tlb = 1'b0;
    for (int t = 0; t < 4; t++) send({OP_SYSCOP, 20'h80000, TOP[t]}, 64'h0, ALL, F_DV);
    send({OP_SYSCOP, 26'h0026000}, 64'h0, ALL, F_DV | F_SR);
    // Sanctioned extension spaces.
    partner_ext_en = 1'b1;
    send({OP_SECOND_SPECIAL_MAJOR_OPCODE, 26'h30}, 64'h0, ALL, F_DV | F_PT);
    partner_ext_en = 1'b0;
    send({OP_SECOND_SPECIAL_MAJOR_OPCODE, 26'h3e}, 64'h0, ALL, F_DV | F_RI);
    {second_coprocessor_opcode_present, cu2_usable} = 2'h3;
    send({OP_SECOND_COPROCESSOR_OPCODE, 26'h2000000}, 64'h0, ALL, F_DV | F_C2);
    for (int c = 0; c < 4; c++) send({C2P[c], 26'h0}, 64'h0, ALL, F_DV | F_C2);
    cu2_usable = 1'b0;
    send({OP_SECOND_COPROCESSOR_OPCODE, 26'h2000000}, 64'h0, ALL, F_DV | F_CPU | 13'h0200);
    {second_coprocessor_opcode_present, cu2_usable} = 2'h1;
    send({OP_SECOND_COPROCESSOR_OPCODE, 26'h2000000}, 64'h0, ALL, F_DV | F_RI);
    send({OP_UNUSED, 26'h0}, 64'h0, ALL, F_DV | F_RI);
    // Result register interlock for each producer kind.
    for (int p = 0; p < 3; p++) begin
      send(PRD[p], 64'h0, ALL, F_DV | F_MD);
      check(hilo_busy, 1'b1);
      send(CNS[p], 64'h0, ~F_MD, F_DV);
      check(stalls, LAT[p]);
      check(hilo_busy, 1'b0);
    end
    send(PRD[0], 64'h0, ALL, F_DV | F_MD);
    send({OP_ADDIU, 26'h0220010}, 64'h0, ALL, F_DV);
    check(stalls, 0);
    send(32'h0000_1010, 64'h0, ~F_MD, F_DV);
    check(stalls, MUL_T - 1);
    instr_valid = 1'b0;
    repeat (2) @(negedge clk);
    print_verdict();
  end

endmodule // tb
